// File: src/jtop_pkg.sv
// shared types and constants for the test access port block
package jtop_pkg;

  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h2,
    TAP_CAP_DR     = 4'h3,
    TAP_SHIFT_DR   = 4'h4,
    TAP_EXIT1_DR   = 4'h5,
    TAP_PAUSE_DR   = 4'h6,
    TAP_EXIT2_DR   = 4'h7,
    TAP_UPD_DR     = 4'h8,
    TAP_SEL_IR     = 4'h9,
    TAP_CAP_IR     = 4'hA,
    TAP_SHIFT_IR   = 4'hB,
    TAP_EXIT1_IR   = 4'hC,
    TAP_PAUSE_IR   = 4'hD,
    TAP_EXIT2_IR   = 4'hE,
    TAP_UPD_IR     = 4'hF
  } jtop_tap_type;

  localparam int unsigned IR_W       = 4;
  localparam int unsigned DR_W       = 32;
  localparam logic [3:0]  IR_BYPASS  = 4'hF;
  localparam logic [3:0]  IR_IDCODE  = 4'h1;
  localparam logic [3:0]  IR_EMUCTL  = 4'h2;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  // arbitrary value, not a real maker or part code
  localparam logic [31:0] IDCODE_VAL = 32'h0000_0001;
  localparam int unsigned EMUCTL_W   = 4;

  // one pin synchroniser: stage[2] oldest, level is the settled value
  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } jtop_sync_type;

  // emulator control: {b_oe, b_out, a_oe, a_out}
  typedef struct packed {
    logic                 tck_prev;
    jtop_tap_type         tap;
    logic [IR_W-1:0]      ir_sh;
    logic [IR_W-1:0]      ir;
    logic [DR_W-1:0]      dr_sh;
    logic [EMUCTL_W-1:0]  emu;
    logic                 tdo;
    logic                 tdo_oe;
    logic                 ev_a_o;
    logic                 ev_a_oe;
    logic                 ev_b_o;
    logic                 ev_b_oe;
    logic                 outs_off;
    logic                 scan_ctl;
  } jtop_state_type;

endpackage : jtop_pkg

// File: src/jtop_port.sv
// test access port with emulator lines and global output disable
// Operation
// - mode select and data in are taken on each test clock rise
// - data out changes only on test clock falls
// - data out floats except while shifting instruction or data
// - data out also floats whenever output disable is active
// - test reset high gives the scan system control of the device
// - test reset low: functional mode, scan inputs ignored
// - test reset high: line a is emulator interrupt, direction set by scan
// - test reset high: line b is emulator interrupt, direction set by scan
// - test reset low: line b becomes active low output disable input
// - output disable active floats every output driver of the device
// - disable needs test reset low, line a high, line b low
`timescale 1ns/1ps
// three-stage pin synchroniser; the level moves once stages two and three agree
module jtop_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // raw pin and its settled level
  input  wire logic pin_i,
  output logic      level_o
);

  jtop_pkg::jtop_sync_type s_q;
  jtop_pkg::jtop_sync_type s_d;

  always_comb begin
    s_d       = s_q;
    s_d.stage = {s_q.stage[1:0], pin_i};
    // a one-cycle glitch never reaches the level
    if (s_q.stage[1] == s_q.stage[2]) begin
      s_d.level = s_q.stage[2];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '{stage: {3{RESET_LEVEL}}, level: RESET_LEVEL};
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.level;

endmodule : jtop_sync

module jtop_port (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // scan pins
  input  wire logic test_clk_i,
  input  wire logic test_mode_sel_i,
  input  wire logic test_data_i,
  input  wire logic test_rst_i,
  output logic      test_data_o,
  output logic      test_data_oe_o,
  // emulator lines, three signals each
  input  wire logic emulator_event_line_a_i,
  output logic      emulator_event_line_a_o,
  output logic      emulator_event_line_a_oe_o,
  input  wire logic emulator_event_line_b_or_output_disable_i,
  output logic      emulator_event_line_b_or_output_disable_o,
  output logic      emulator_event_line_b_or_output_disable_oe_o,
  // to the rest of the device
  output logic      outputs_off_o,
  output logic      scan_control_o
);

  jtop_pkg::jtop_state_type s_q;
  jtop_pkg::jtop_state_type s_d;

  // settled pin levels, one synchroniser per pin
  logic tck_s, tms_s, tdi_s, trst_s, ev_a_s, ev_b_s;
  logic rise, fall;

  jtop_sync #(.RESET_LEVEL(1'b0)) i_sync_tck (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (test_clk_i),
    .level_o (tck_s)
  );

  // mode select and data in start at their pull-up level
  jtop_sync #(.RESET_LEVEL(1'b1)) i_sync_tms (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (test_mode_sel_i),
    .level_o (tms_s)
  );

  jtop_sync #(.RESET_LEVEL(1'b1)) i_sync_tdi (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (test_data_i),
    .level_o (tdi_s)
  );

  jtop_sync #(.RESET_LEVEL(1'b0)) i_sync_trst (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (test_rst_i),
    .level_o (trst_s)
  );

  // line a starts low so no false disable follows reset
  jtop_sync #(.RESET_LEVEL(1'b0)) i_sync_ev_a (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (emulator_event_line_a_i),
    .level_o (ev_a_s)
  );

  jtop_sync #(.RESET_LEVEL(1'b1)) i_sync_ev_b (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (emulator_event_line_b_or_output_disable_i),
    .level_o (ev_b_s)
  );

  always_comb begin
    // reset level of the clock history matches the idle pin: no false edge
    rise = tck_s && !s_q.tck_prev;
    fall = !tck_s && s_q.tck_prev;
  end

  function automatic jtop_pkg::jtop_tap_type next_tap(input jtop_pkg::jtop_tap_type t,
                                                      input logic m);
    unique case (t)
      jtop_pkg::TAP_RESET:    next_tap = m ? jtop_pkg::TAP_RESET    : jtop_pkg::TAP_IDLE;
      jtop_pkg::TAP_IDLE:     next_tap = m ? jtop_pkg::TAP_SEL_DR   : jtop_pkg::TAP_IDLE;
      jtop_pkg::TAP_SEL_DR:   next_tap = m ? jtop_pkg::TAP_SEL_IR   : jtop_pkg::TAP_CAP_DR;
      jtop_pkg::TAP_CAP_DR:   next_tap = m ? jtop_pkg::TAP_EXIT1_DR : jtop_pkg::TAP_SHIFT_DR;
      jtop_pkg::TAP_SHIFT_DR: next_tap = m ? jtop_pkg::TAP_EXIT1_DR : jtop_pkg::TAP_SHIFT_DR;
      jtop_pkg::TAP_EXIT1_DR: next_tap = m ? jtop_pkg::TAP_UPD_DR   : jtop_pkg::TAP_PAUSE_DR;
      jtop_pkg::TAP_PAUSE_DR: next_tap = m ? jtop_pkg::TAP_EXIT2_DR : jtop_pkg::TAP_PAUSE_DR;
      jtop_pkg::TAP_EXIT2_DR: next_tap = m ? jtop_pkg::TAP_UPD_DR   : jtop_pkg::TAP_SHIFT_DR;
      jtop_pkg::TAP_UPD_DR:   next_tap = m ? jtop_pkg::TAP_SEL_DR   : jtop_pkg::TAP_IDLE;
      jtop_pkg::TAP_SEL_IR:   next_tap = m ? jtop_pkg::TAP_RESET    : jtop_pkg::TAP_CAP_IR;
      jtop_pkg::TAP_CAP_IR:   next_tap = m ? jtop_pkg::TAP_EXIT1_IR : jtop_pkg::TAP_SHIFT_IR;
      jtop_pkg::TAP_SHIFT_IR: next_tap = m ? jtop_pkg::TAP_EXIT1_IR : jtop_pkg::TAP_SHIFT_IR;
      jtop_pkg::TAP_EXIT1_IR: next_tap = m ? jtop_pkg::TAP_UPD_IR   : jtop_pkg::TAP_PAUSE_IR;
      jtop_pkg::TAP_PAUSE_IR: next_tap = m ? jtop_pkg::TAP_EXIT2_IR : jtop_pkg::TAP_PAUSE_IR;
      jtop_pkg::TAP_EXIT2_IR: next_tap = m ? jtop_pkg::TAP_UPD_IR   : jtop_pkg::TAP_SHIFT_IR;
      jtop_pkg::TAP_UPD_IR:   next_tap = m ? jtop_pkg::TAP_SEL_DR   : jtop_pkg::TAP_IDLE;
    endcase
  endfunction : next_tap

  always_comb begin
    s_d = s_q;
    s_d.tck_prev = tck_s;
    s_d.scan_ctl = trst_s;

    if (!trst_s) begin
      // functional mode: scan pins ignored, controller parked
      s_d.tap   = jtop_pkg::TAP_RESET;
      s_d.ir    = jtop_pkg::IR_IDCODE;
      s_d.emu   = '0;
      s_d.tdo_oe = 1'b0;
      // line b read as output disable, gated by line a high
      s_d.outs_off = ev_a_s && !ev_b_s;
    end else begin
      s_d.outs_off = 1'b0;
      if (rise) begin
        s_d.tap = next_tap(s_q.tap, tms_s);
        unique case (s_q.tap)
          jtop_pkg::TAP_RESET: begin
            s_d.ir  = jtop_pkg::IR_IDCODE;
            s_d.emu = '0;
          end
          jtop_pkg::TAP_CAP_IR: s_d.ir_sh = jtop_pkg::IR_CAPTURE;
          jtop_pkg::TAP_SHIFT_IR: s_d.ir_sh = {tdi_s, s_q.ir_sh[jtop_pkg::IR_W-1:1]};
          jtop_pkg::TAP_UPD_IR: s_d.ir = s_q.ir_sh;
          jtop_pkg::TAP_CAP_DR: begin
            if (s_q.ir == jtop_pkg::IR_IDCODE)
              s_d.dr_sh = jtop_pkg::IDCODE_VAL;
            else if (s_q.ir == jtop_pkg::IR_EMUCTL)
              s_d.dr_sh = {{(jtop_pkg::DR_W-jtop_pkg::EMUCTL_W){1'b0}}, s_q.emu};
            else
              s_d.dr_sh = '0;
          end
          jtop_pkg::TAP_SHIFT_DR: begin
            if (s_q.ir == jtop_pkg::IR_IDCODE)
              s_d.dr_sh = {tdi_s, s_q.dr_sh[jtop_pkg::DR_W-1:1]};
            else if (s_q.ir == jtop_pkg::IR_EMUCTL)
              s_d.dr_sh[jtop_pkg::EMUCTL_W-1:0] =
                {tdi_s, s_q.dr_sh[jtop_pkg::EMUCTL_W-1:1]};
            else
              s_d.dr_sh[0] = tdi_s;
          end
          // emulator line directions chosen by scan
          jtop_pkg::TAP_UPD_DR:
            if (s_q.ir == jtop_pkg::IR_EMUCTL) s_d.emu = s_q.dr_sh[jtop_pkg::EMUCTL_W-1:0];
          default: ;
        endcase
      end
      if (fall) begin
        s_d.tdo_oe = (s_q.tap == jtop_pkg::TAP_SHIFT_DR) ||
                     (s_q.tap == jtop_pkg::TAP_SHIFT_IR);
        s_d.tdo    = (s_q.tap == jtop_pkg::TAP_SHIFT_IR) ? s_q.ir_sh[0] : s_q.dr_sh[0];
      end
    end

    s_d.ev_a_o  = s_d.emu[0];
    s_d.ev_a_oe = trst_s && s_d.emu[1] && !s_d.outs_off;
    s_d.ev_b_o  = s_d.emu[2];
    s_d.ev_b_oe = trst_s && s_d.emu[3] && !s_d.outs_off;
    s_d.tdo_oe  = s_d.tdo_oe && !s_d.outs_off;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '{tck_prev: 1'b0, tap: jtop_pkg::TAP_RESET,
               ir_sh: '0, ir: jtop_pkg::IR_IDCODE, dr_sh: '0, emu: '0,
               tdo: 1'b0, tdo_oe: 1'b0, ev_a_o: 1'b0, ev_a_oe: 1'b0,
               ev_b_o: 1'b0, ev_b_oe: 1'b0, outs_off: 1'b0, scan_ctl: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign test_data_o    = s_q.tdo;
  // enable register carries the output disable override
  assign test_data_oe_o = s_q.tdo_oe;
  assign emulator_event_line_a_o  = s_q.ev_a_o;
  assign emulator_event_line_a_oe_o = s_q.ev_a_oe;
  assign emulator_event_line_b_or_output_disable_o  = s_q.ev_b_o;
  assign emulator_event_line_b_or_output_disable_oe_o = s_q.ev_b_oe;
  assign outputs_off_o  = s_q.outs_off;
  assign scan_control_o = s_q.scan_ctl;

endmodule : jtop_port

// File: verification/jtop_port_asserts.sv
// pin-level checks for the test access port
`timescale 1ns/1ps
module jtop_port_asserts (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // scan pins
  input wire logic test_clk_i,
  input wire logic test_rst_i,
  input wire logic test_data_o,
  input wire logic test_data_oe_o,
  // emulator lines and device controls
  input wire logic emulator_event_line_a_i,
  input wire logic emulator_event_line_b_or_output_disable_i,
  input wire logic emulator_event_line_a_oe_o,
  input wire logic emulator_event_line_b_or_output_disable_oe_o,
  input wire logic outputs_off_o,
  input wire logic scan_control_o
);
  wire logic req = !test_rst_i && emulator_event_line_a_i
                   && !emulator_event_line_b_or_output_disable_i;
  wire logic oes = emulator_event_line_a_oe_o || emulator_event_line_b_or_output_disable_oe_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; req [*6]; endsequence
  sequence s_func; (!test_rst_i) [*8]; endsequence
  property p_off_tdo; outputs_off_o |-> !test_data_oe_o; endproperty
  a_off_tdo: assert property (p_off_tdo) else $error("tdo on while off");
  property p_off_lines; outputs_off_o |-> !oes; endproperty
  a_off_lines: assert property (p_off_lines) else $error("line on while off");
  // data out moves only a few cycles after a test clock fall
  property p_tdo_fall; $changed(test_data_oe_o) || test_data_oe_o && $changed(test_data_o)
    |-> !$past(test_clk_i, 3); endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off fall");
  property p_off_rise; $rose(outputs_off_o) |-> $past(req, 5); endproperty
  a_off_rise: assert property (p_off_rise) else $error("off without cause");
  property p_off_resp; s_req |-> outputs_off_o; endproperty
  a_off_resp: assert property (p_off_resp) else $error("off not taken");
  property p_no_off; test_rst_i [*6] |-> !outputs_off_o; endproperty
  a_no_off: assert property (p_no_off) else $error("off in scan mode");
  property p_func; s_func |-> !test_data_oe_o && !scan_control_o && !oes; endproperty
  a_func: assert property (p_func) else $error("scan active in func");
  property p_scan; test_rst_i [*8] |-> scan_control_o; endproperty
  a_scan: assert property (p_scan) else $error("scan not in control");
endmodule : jtop_port_asserts
bind jtop_port jtop_port_asserts i_chk (
  .mclk_i                                       (mclk_i),
  .rst_i                                        (rst_i),
  .test_clk_i                                   (test_clk_i),
  .test_rst_i                                   (test_rst_i),
  .test_data_o                                  (test_data_o),
  .test_data_oe_o                               (test_data_oe_o),
  .emulator_event_line_a_i                      (emulator_event_line_a_i),
  .emulator_event_line_b_or_output_disable_i    (emulator_event_line_b_or_output_disable_i),
  .emulator_event_line_a_oe_o                   (emulator_event_line_a_oe_o),
  .emulator_event_line_b_or_output_disable_oe_o (emulator_event_line_b_or_output_disable_oe_o),
  .outputs_off_o                                (outputs_off_o),
  .scan_control_o                               (scan_control_o)
);

// File: verification/jtop_tester.sv
// behavioural boundary-scan tester driving the scan pins
`timescale 1ns/1ps
module jtop_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  // clock idles low between frames, data in at its pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // data out read late in the high phase, it only moves on falls
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #24 tck_o = 1'b1;
    #23 q = tdo_oe_i ? tdo_i : 1'bz;
    #1 tck_o = 1'b0;
  endtask : step
  task automatic walk(input logic [15:0] s, input int n, output logic q);
    for (int i = 0; i < n; i++) step(s[i], 1'b1, q);
  endtask : walk
  task automatic scan(input int n, input logic [31:0] di, output logic [31:0] dq);
    dq = '0;
    for (int i = 0; i < n; i++) step(i == n - 1, di[i], dq[i]);
  endtask : scan
endmodule : jtop_tester

// File: verification/tb_jtop_port.sv
// self-checking bench for the test access port
`timescale 1ns/1ps
module tb_jtop_port;
  logic mclk_i = 1'b0, rst_i = 1'b1, trst = 1'b0;
  logic a_en = 1'b0, a_val = 1'b1, b_en = 1'b0, b_val = 1'b1, b;
  wire logic tck, tms, tdi, tdo, toe, a_o, a_oe, b_o, b_oe, off, scn, pin_a, pin_b;
  int bad_count = 0, tests_run = 0, cyc = 0;
  logic [31:0] got;
  // pulled-up lines: the device, else the bench, else high
  assign pin_a = a_oe ? a_o : (a_en ? a_val : 1'b1);
  assign pin_b = b_oe ? b_o : (b_en ? b_val : 1'b1);
  jtop_port i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .test_clk_i(tck), .test_mode_sel_i(tms),
    .test_data_i(tdi), .test_rst_i(trst), .test_data_o(tdo), .test_data_oe_o(toe),
    .emulator_event_line_a_i(pin_a), .emulator_event_line_a_o(a_o),
    .emulator_event_line_a_oe_o(a_oe), .emulator_event_line_b_or_output_disable_i(pin_b),
    .emulator_event_line_b_or_output_disable_o(b_o),
    .emulator_event_line_b_or_output_disable_oe_o(b_oe), .outputs_off_o(off),
    .scan_control_o(scn));
  jtop_tester i_tst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(toe));
  initial forever #2.5 mclk_i = ~mclk_i;
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out;
    $display("mismatches %0d checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic t_idcode;
    i_tst.walk(16'h004F, 9, b);
    i_tst.scan(32, 32'h0, got);
    chk(got, jtop_pkg::IDCODE_VAL);
    i_tst.walk(16'h0001, 1, b);
    chk(b, 1'bz);
  endtask : t_idcode
  task automatic t_emu;
    i_tst.walk(16'h0003, 4, b);
    i_tst.scan(4, {28'h0, jtop_pkg::IR_EMUCTL}, got);
    chk(got[3:0], jtop_pkg::IR_CAPTURE);
    i_tst.walk(16'h0003, 4, b);
    i_tst.scan(4, 32'hB, got);
    i_tst.walk(16'h0001, 2, b);
    wt(10);
    chk({b_oe, b_o, a_oe, a_o, scn}, 5'h17);
  endtask : t_emu
  task automatic t_func;
    trst <= 1'b0;
    wt(12);
    chk({scn, toe, a_oe, b_oe}, 4'h0);
    i_tst.walk(16'h0002, 5, b);
    chk(b, 1'bz);
    // off request used only as a test condition
    {a_en, a_val, b_en, b_val} <= 4'hE;
    wt(8);
    chk({off, toe}, 2'b10);
    a_val <= 1'b0;
    wt(8);
    chk(off, 1'b0);
    {a_val, trst} <= 2'b11;
    wt(10);
    chk(off, 1'b0);
  endtask : t_func
  initial begin
    wt(3);
    rst_i <= 1'b0;
    wt(6);
    trst <= 1'b1;
    wt(10);
    t_idcode();
    t_emu();
    t_func();
    close_out();
  end
endmodule : tb_jtop_port
